// >>> hub_event_regs.sv
// Purpose: Reset controls, held event status, mask and pending output.
// Assumes: Register port and port signals are on the i_clk domain.
// Notes: A read or write is answered by o_reg_ack one cycle later.
`timescale 1ns/1ps
`default_nettype none
module hub_event_regs #(
    parameter int unsigned JAB100_LIM = hub_evt_pkg::JAB100_CYC,
    parameter int unsigned JAB10_LIM = hub_evt_pkg::JAB10_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [hub_evt_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [hub_evt_pkg::DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_clear_mode,
    input wire logic [hub_evt_pkg::PORTS-1:0] i_speed_100,
    input wire logic [hub_evt_pkg::PORTS-1:0] i_rx_active,
    input wire logic [hub_evt_pkg::PORTS-1:0] i_tx_active,
    input wire logic [hub_evt_pkg::PORTS-1:0] i_frame_start,
    input wire logic [hub_evt_pkg::PORTS-1:0] i_jk_ok,
    input wire logic [hub_evt_pkg::PORTS-1:0] i_col_frame,
    input wire logic [hub_evt_pkg::PORTS-1:0] i_clean_frame,
    input wire logic [hub_evt_pkg::PORTS-1:0] i_fcc_excess,
    input wire logic [hub_evt_pkg::PORTS-1:0] i_sa_valid,
    input wire logic [hub_evt_pkg::PORTS*hub_evt_pkg::SA_W-1:0] i_src_addr,
    output logic [hub_evt_pkg::DATA_W-1:0] o_reg_rdata,
    output logic o_reg_ack,
    output logic o_event_pending,
    output logic o_core_reset,
    output logic o_chip_reset,
    output logic o_jabber,
    output logic [hub_evt_pkg::PORTS-1:0] o_tx_inhibit,
    output logic [hub_evt_pkg::PORTS-1:0] o_port_isolated,
    output logic [hub_evt_pkg::PORTS-1:0] o_port_partitioned,
    output logic [hub_evt_pkg::PORTS-1:0] o_rx_repeat_en
);
    import hub_evt_pkg::*;

    // ==========================================================
    // State

    typedef struct packed {
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic jab100;
        logic [DATA_W-1:0] rdata;
        logic ack;
        logic pending;
        logic core_rst;
        logic chip_rst;
        logic jabber;
        logic [PORTS-1:0] repeat_en;
    } regs_st_t;

    regs_st_t st_ff;
    regs_st_t nxt_st;

    // Per-port monitor results.
    logic [PORTS-1:0] rx_over;
    logic [PORTS-1:0] jab10;
    logic [PORTS-1:0] isolate;
    logic [PORTS-1:0] partition;
    logic [PORTS-1:0] iso_ev;
    logic [PORTS-1:0] part_ev;
    logic [PORTS-1:0] sa_ev;
    logic [PORTS-1:0] spd_ev;

    // Combined events and clear masks.
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic jab_cond;

    // ==========================================================
    // Port monitors

    // One monitor per repeater port.
    genvar gp;
    generate
        for (gp = 0; gp < PORTS; gp = gp + 1) begin : g_port
            port_monitor #(
                .JAB100_LIM(JAB100_LIM),
                .JAB10_LIM(JAB10_LIM)
            ) i_port_monitor (
                .i_clk(i_clk),
                .i_resetn(i_resetn),
                .i_core_clear(st_ff.core_rst),
                .i_chip_clear(st_ff.chip_rst),
                .i_speed_100(i_speed_100[gp]),
                .i_rx_active(i_rx_active[gp]),
                .i_tx_active(i_tx_active[gp]),
                .i_frame_start(i_frame_start[gp]),
                .i_jk_ok(i_jk_ok[gp]),
                .i_col_frame(i_col_frame[gp]),
                .i_clean_frame(i_clean_frame[gp]),
                .i_sa_valid(i_sa_valid[gp]),
                .i_src_addr(i_src_addr[gp*SA_W +: SA_W]),
                .o_rx_over(rx_over[gp]),
                .o_jab10(jab10[gp]),
                .o_isolate(isolate[gp]),
                .o_partition(partition[gp]),
                .o_iso_ev(iso_ev[gp]),
                .o_part_ev(part_ev[gp]),
                .o_sa_ev(sa_ev[gp]),
                .o_spd_ev(spd_ev[gp])
            );
        end
    endgenerate

    // ==========================================================
    // Event gathering

    // Jabber is a level: held by the receive state or any transmitter.
    assign jab_cond = st_ff.jab100 | (|jab10);

    // Each status bit is fed by the OR of its port events.
    always_comb begin
        evt_set = '0;
        evt_set[JABBER_BIT] = jab_cond;
        evt_set[ISOLATE_BIT] = |iso_ev;
        evt_set[PARTITION_BIT] = |part_ev;
        evt_set[FALSE_CARRIER_BIT] = |i_fcc_excess;
        evt_set[SRC_ADDR_BIT] = |sa_ev;
        evt_set[SPEED_BIT] = |spd_ev;
    end

    // ==========================================================
    // Register access and next state

    // Decodes reads and writes, applies clears, then sets.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = 1'b0;
        nxt_st.rdata = '0;
        nxt_st.core_rst = 1'b0;
        nxt_st.chip_rst = 1'b0;
        evt_clr = '0;
        if (st_ff.chip_rst) begin
            // Software reset returns everything to its reset value.
            nxt_st = '0;
            nxt_st.status = STATUS_RESET;
            nxt_st.mask = MASK_RESET;
        end else begin
            // Register reads; reserved bits read as zero.
            if (i_reg_rd) begin
                nxt_st.ack = 1'b1;
                case (i_reg_addr)
                    STATUS_ADDR: begin
                        nxt_st.rdata = {{(DATA_W - EVT_W){1'b0}},
                            st_ff.status};
                        if (!i_reg_clear_mode) begin
                            evt_clr = st_ff.status;
                        end
                    end
                    MASK_ADDR: begin
                        nxt_st.rdata = {{(DATA_W - EVT_W){1'b0}},
                            st_ff.mask};
                    end
                    default: begin
                        nxt_st.rdata = '0;
                    end
                endcase
            end
            // Register writes; reset bits act once and read as zero.
            if (i_reg_wr) begin
                nxt_st.ack = 1'b1;
                case (i_reg_addr)
                    STATUS_ADDR: begin
                        if (i_reg_clear_mode) begin
                            evt_clr = evt_clr |
                                i_reg_wdata[EVT_W-1:0];
                        end
                    end
                    MASK_ADDR: begin
                        nxt_st.mask = i_reg_wdata[EVT_W-1:0];
                    end
                    CORE_RST_ADDR: begin
                        nxt_st.core_rst = i_reg_wdata[RESET_BIT];
                    end
                    CHIP_RST_ADDR: begin
                        nxt_st.chip_rst = i_reg_wdata[RESET_BIT];
                    end
                    default: begin
                        nxt_st.mask = st_ff.mask;
                    end
                endcase
            end
            // Held status: a set in the clearing cycle survives.
            nxt_st.status = (st_ff.status & ~evt_clr) | evt_set;
            // Receive jabber holds until every receiver is idle.
            if (|rx_over) begin
                nxt_st.jab100 = 1'b1;
            end else if (~|i_rx_active) begin
                nxt_st.jab100 = 1'b0;
            end
            // Core reset also drops the shared receive jabber.
            if (st_ff.core_rst) begin
                nxt_st.jab100 = 1'b0;
            end
            nxt_st.jabber = jab_cond;
            // Partitioned or isolated ports are not repeated.
            nxt_st.repeat_en = ~(partition | isolate);
            // Pending follows the status and mask being loaded.
            nxt_st.pending = |(nxt_st.status & ~nxt_st.mask);
        end
    end

    // State register.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs

    // All outputs come from flip-flops here or in the monitors.
    assign o_reg_rdata = st_ff.rdata;
    assign o_reg_ack = st_ff.ack;
    assign o_event_pending = st_ff.pending;
    assign o_core_reset = st_ff.core_rst;
    assign o_chip_reset = st_ff.chip_rst;
    assign o_jabber = st_ff.jabber;
    assign o_tx_inhibit = jab10;
    assign o_port_isolated = isolate;
    assign o_port_partitioned = partition;
    assign o_rx_repeat_en = st_ff.repeat_en;
endmodule
`default_nettype wire

// >>> hub_evt_pkg.sv
// Purpose: Shared constants for the hub reset and port event registers.
// Assumes: 40 MHz core clock, eight repeater ports, 8-bit register index.
// Notes: Times are kept in their own units; cycle counts derive from them.
//
// Summary of operation
// - Writing one to core reset bit 0 clears repeater core only.
// - Writing one to chip reset bit 0 acts like a hardware reset.
// - Status register 146 holds each event bit until cleared.
// - Mask register 147: bit one masks, bits 5..0 match status, reset 0.
// - 100 Mbps jabber after 57,500 bit times active; ends when all idle.
// - 10 Mbps transmit jabber after 40,000-75,000 bits forces min idle gap.
// - Status bit 5 is set while any port is jabbering.
// - At 100 Mbps, third successive false carrier isolates port, sets bit 4.
// - A frame not starting with the /J/K pair is a false carrier.
// - At 100 Mbps, over 60 consecutive collisions partitions, sets bit 3.
// - At 10 Mbps, over 31 consecutive collisions partitions the port.
// - Partitioned port is monitored and sent to, but not repeated.
// - Status bit 2 is set on excessive false carrier count.
// - Status bit 1 is set when a port source address changes.
// - Status bit 0 is set when any port changes link speed.
// - Clear mode one: write one clears; zero: read clears status.
// - Bits 31..6 of status and mask are reserved and read zero.
package hub_evt_pkg;

    // ==========================================================
    // Sizes
    localparam int unsigned PORTS = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned EVT_W = 6;
    localparam int unsigned SA_W = 48;
    localparam int unsigned CNT_W = 18;
    localparam int unsigned IFG_W = 9;
    localparam int unsigned COL_W = 6;

    // ==========================================================
    // Register indices
    localparam logic [7:0] STATUS_ADDR = 8'h92;
    localparam logic [7:0] MASK_ADDR = 8'h93;
    localparam logic [7:0] CORE_RST_ADDR = 8'h9A;
    localparam logic [7:0] CHIP_RST_ADDR = 8'h9B;
    localparam logic [5:0] STATUS_RESET = 6'h00;
    localparam logic [5:0] MASK_RESET = 6'h00;

    // ==========================================================
    // Field positions
    localparam int unsigned RESET_BIT = 0;
    localparam int unsigned JABBER_BIT = 5;
    localparam int unsigned ISOLATE_BIT = 4;
    localparam int unsigned PARTITION_BIT = 3;
    localparam int unsigned FALSE_CARRIER_BIT = 2;
    localparam int unsigned SRC_ADDR_BIT = 1;
    localparam int unsigned SPEED_BIT = 0;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_NS = 25;
    localparam int unsigned BIT_NS_100 = 10;
    localparam int unsigned BIT_NS_10 = 100;
    localparam int unsigned JAB100_BITS = 57500;
    localparam int unsigned JAB10_BITS = 40000;
    localparam int unsigned IFG_BITS = 96;
    localparam int unsigned JAB100_CYC =
        (JAB100_BITS * BIT_NS_100 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned JAB10_CYC =
        (JAB10_BITS * BIT_NS_10 + CLK_NS - 1) / CLK_NS;
    localparam logic [8:0] IFG_CYC =
        9'((IFG_BITS * BIT_NS_10 + CLK_NS - 1) / CLK_NS);

    // ==========================================================
    // Event limits
    localparam logic [1:0] ISO_FC_LIMIT = 2'h2;
    localparam logic [5:0] PART_LIM_100 = 6'h3C;
    localparam logic [5:0] PART_LIM_10 = 6'h1F;

endpackage

// >>> port_monitor.sv
// Purpose: Per-port jabber, isolation, partition, speed and address watch.
// Assumes: Inputs come from port logic and, for the clears, the register block, on the same clock.
// Notes: Core clear spares the last source address and speed history.
`timescale 1ns/1ps
`default_nettype none
module port_monitor #(
    parameter int unsigned JAB100_LIM = hub_evt_pkg::JAB100_CYC,
    parameter int unsigned JAB10_LIM = hub_evt_pkg::JAB10_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_core_clear,
    input wire logic i_chip_clear,
    input wire logic i_speed_100,
    input wire logic i_rx_active,
    input wire logic i_tx_active,
    input wire logic i_frame_start,
    input wire logic i_jk_ok,
    input wire logic i_col_frame,
    input wire logic i_clean_frame,
    input wire logic i_sa_valid,
    input wire logic [hub_evt_pkg::SA_W-1:0] i_src_addr,
    output logic o_rx_over,
    output logic o_jab10,
    output logic o_isolate,
    output logic o_partition,
    output logic o_iso_ev,
    output logic o_part_ev,
    output logic o_sa_ev,
    output logic o_spd_ev
);
    import hub_evt_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] rx_cnt;
        logic rx_over;
        logic [CNT_W-1:0] tx_cnt;
        logic jab10;
        logic [IFG_W-1:0] gap_cnt;
        logic [1:0] fc_cnt;
        logic isolate;
        logic [COL_W-1:0] col_cnt;
        logic partition;
        logic spd_prev;
        logic spd_seen;
        logic [SA_W-1:0] last_sa;
        logic sa_seen;
        logic iso_ev;
        logic part_ev;
        logic sa_ev;
        logic spd_ev;
    } mon_st_t;

    localparam logic [CNT_W-1:0] RX_LIM = CNT_W'(JAB100_LIM);
    localparam logic [CNT_W-1:0] TX_LIM = CNT_W'(JAB10_LIM);

    mon_st_t st_ff;
    mon_st_t nxt_st;
    logic [COL_W-1:0] col_lim;

    // Next-state logic for one port.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.iso_ev = 1'b0;
        nxt_st.part_ev = 1'b0;
        nxt_st.sa_ev = 1'b0;
        nxt_st.spd_ev = 1'b0;
        col_lim = i_speed_100 ? PART_LIM_100 : PART_LIM_10;
        if (i_chip_clear) begin
            nxt_st = '0;
        end else begin
            // Receive jabber watch at 100 Mbps.
            if (i_speed_100 && i_rx_active) begin
                if (st_ff.rx_cnt >= RX_LIM) begin
                    nxt_st.rx_over = 1'b1;
                end else begin
                    nxt_st.rx_cnt = st_ff.rx_cnt + 1'b1;
                end
            end else begin
                nxt_st.rx_cnt = '0;
                nxt_st.rx_over = 1'b0;
            end
            // Transmit jabber at 10 Mbps, then a forced idle gap.
            if (st_ff.jab10) begin
                if (i_tx_active) begin
                    nxt_st.gap_cnt = '0;
                end else if (st_ff.gap_cnt >= IFG_CYC - 1'b1) begin
                    nxt_st.jab10 = 1'b0;
                    nxt_st.tx_cnt = '0;
                end else begin
                    nxt_st.gap_cnt = st_ff.gap_cnt + 1'b1;
                end
            end else if (!i_speed_100 && i_tx_active) begin
                if (st_ff.tx_cnt >= TX_LIM) begin
                    nxt_st.jab10 = 1'b1;
                    nxt_st.gap_cnt = '0;
                end else begin
                    nxt_st.tx_cnt = st_ff.tx_cnt + 1'b1;
                end
            end else begin
                nxt_st.tx_cnt = '0;
            end
            // Successive false carriers isolate the port.
            if (i_frame_start) begin
                if (i_jk_ok) begin
                    nxt_st.fc_cnt = '0;
                    nxt_st.isolate = 1'b0;
                end else if (i_speed_100) begin
                    if (st_ff.fc_cnt == ISO_FC_LIMIT) begin
                        nxt_st.isolate = 1'b1;
                        nxt_st.iso_ev = !st_ff.isolate;
                    end else begin
                        nxt_st.fc_cnt = st_ff.fc_cnt + 1'b1;
                    end
                end
            end
            // Consecutive collisions partition the port.
            if (i_col_frame) begin
                if (st_ff.col_cnt >= col_lim) begin
                    nxt_st.partition = 1'b1;
                    nxt_st.part_ev = !st_ff.partition;
                end else begin
                    nxt_st.col_cnt = st_ff.col_cnt + 1'b1;
                end
            end else if (i_clean_frame) begin
                nxt_st.col_cnt = '0;
                nxt_st.partition = 1'b0;
            end
            // Speed history.
            nxt_st.spd_seen = 1'b1;
            nxt_st.spd_prev = i_speed_100;
            if (st_ff.spd_seen && st_ff.spd_prev != i_speed_100) begin
                nxt_st.spd_ev = 1'b1;
            end
            // Source address tracking.
            if (i_sa_valid) begin
                nxt_st.sa_ev = st_ff.sa_seen &&
                    (st_ff.last_sa != i_src_addr);
                nxt_st.last_sa = i_src_addr;
                nxt_st.sa_seen = 1'b1;
            end
            // Core clear drops repeater state only.
            if (i_core_clear) begin
                nxt_st.rx_cnt = '0;
                nxt_st.rx_over = 1'b0;
                nxt_st.tx_cnt = '0;
                nxt_st.jab10 = 1'b0;
                nxt_st.gap_cnt = '0;
                nxt_st.fc_cnt = '0;
                nxt_st.isolate = 1'b0;
                nxt_st.col_cnt = '0;
                nxt_st.partition = 1'b0;
                nxt_st.iso_ev = 1'b0;
                nxt_st.part_ev = 1'b0;
            end
        end
    end

    // State register.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register.
    assign o_rx_over = st_ff.rx_over;
    assign o_jab10 = st_ff.jab10;
    assign o_isolate = st_ff.isolate;
    assign o_partition = st_ff.partition;
    assign o_iso_ev = st_ff.iso_ev;
    assign o_part_ev = st_ff.part_ev;
    assign o_sa_ev = st_ff.sa_ev;
    assign o_spd_ev = st_ff.spd_ev;
endmodule
`default_nettype wire

// >>> hub_event_regs_chk.sv
// Purpose: Port-level assertions for the hub event register block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Attached to the design top by the bind below.
`timescale 1ns/1ps
`default_nettype none
module hub_event_regs_chk (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [hub_evt_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [hub_evt_pkg::DATA_W-1:0] i_reg_wdata,
    input wire logic [hub_evt_pkg::PORTS-1:0] i_rx_active,
    input wire logic [hub_evt_pkg::DATA_W-1:0] o_reg_rdata,
    input wire logic o_reg_ack,
    input wire logic o_event_pending,
    input wire logic o_core_reset,
    input wire logic o_chip_reset,
    input wire logic o_jabber,
    input wire logic [hub_evt_pkg::PORTS-1:0] o_tx_inhibit,
    input wire logic [hub_evt_pkg::PORTS-1:0] o_port_isolated,
    input wire logic [hub_evt_pkg::PORTS-1:0] o_port_partitioned,
    input wire logic [hub_evt_pkg::PORTS-1:0] o_rx_repeat_en
);
    import hub_evt_pkg::*;
    // ==========================================================
    // Helpers
    logic take;
    logic wr1;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // An access in the chip-clear cycle is dropped, so it is excluded.
    assign take = (i_reg_rd || i_reg_wr) && !o_chip_reset;
    assign wr1 = i_reg_wr && i_reg_wdata[0] && !o_chip_reset;
    sequence s_core;
        o_core_reset ##1 !o_core_reset;
    endsequence
    sequence s_chip;
        o_chip_reset ##1 !o_chip_reset;
    endsequence
    // ==========================================================
    // Properties
    a_ack_one_later: assert property (take |=> o_reg_ack)
        else $error("register access not acknowledged");
    a_rdata_idle_zero: assert property (!o_reg_ack |-> !o_reg_rdata)
        else $error("read data not zero while idle");
    a_reserved_zero: assert property (!o_reg_rdata[31:6])
        else $error("reserved read bits set");
    a_core_pulse: assert property (
        wr1 && i_reg_addr == CORE_RST_ADDR |=> s_core)
        else $error("core reset pulse wrong");
    a_chip_pulse: assert property (
        wr1 && i_reg_addr == CHIP_RST_ADDR |=> s_chip)
        else $error("chip reset pulse wrong");
    a_chip_clears: assert property (
        o_chip_reset |=> !o_event_pending && !o_jabber &&
        !o_port_isolated && !o_port_partitioned)
        else $error("chip reset left state");
    a_repeat_follows: assert property (
        $past(i_resetn) && !$past(o_chip_reset) && !$past(o_chip_reset, 2)
        |-> o_rx_repeat_en == ~$past(o_port_partitioned | o_port_isolated))
        else $error("repeat enable mismatch");
    a_jabber_clears: assert property (
        (i_rx_active == '0 && o_tx_inhibit == '0) [*4] |-> !o_jabber)
        else $error("jabber stays after idle");
endmodule
bind hub_event_regs hub_event_regs_chk i_chk (.i_clk, .i_resetn, .i_reg_rd,
    .i_reg_wr, .i_reg_addr, .i_reg_wdata, .i_rx_active, .o_reg_rdata,
    .o_reg_ack, .o_event_pending, .o_core_reset, .o_chip_reset, .o_jabber,
    .o_tx_inhibit, .o_port_isolated, .o_port_partitioned, .o_rx_repeat_en);
`default_nettype wire

// >>> hub_event_regs_tb.sv
// Purpose: Self-checking bench for the hub event register block.
// Assumes: Short jabber limits of 20 and 30 cycles.
// Notes: Ports 3 and 6 run at 10 Mbps, the rest at 100 Mbps until t_speed moves port 0 to 10 Mbps.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
$display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module hub_event_regs_tb;
    import hub_evt_pkg::*;
    localparam int J100 = 20;
    localparam int J10 = 30;
    logic i_clk = 1'b0, i_resetn = 1'b0, i_reg_rd = 1'b0, i_reg_wr = 1'b0;
    logic i_reg_clear_mode = 1'b1;
    logic [7:0] i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0000_0000, o_reg_rdata, v;
    logic [7:0] i_speed_100 = 8'hB7, i_rx_active = '0, i_tx_active = '0;
    logic [7:0] i_frame_start = '0, i_jk_ok = '0, i_col_frame = '0;
    logic [7:0] i_clean_frame = '0, i_fcc_excess = '0, i_sa_valid = '0;
    logic [383:0] i_src_addr = '0;
    logic o_reg_ack, o_event_pending, o_core_reset, o_chip_reset, o_jabber;
    logic [7:0] o_tx_inhibit, o_port_isolated, o_port_partitioned;
    logic [7:0] o_rx_repeat_en;
    int n_errors = 0, checks_done = 0, cyc = 0;
    hub_event_regs #(.JAB100_LIM(J100), .JAB10_LIM(J10)) i_hub_event_regs (
        .i_clk, .i_resetn, .i_reg_rd, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
        .i_reg_clear_mode, .i_speed_100, .i_rx_active, .i_tx_active,
        .i_frame_start, .i_jk_ok, .i_col_frame, .i_clean_frame, .i_fcc_excess,
        .i_sa_valid, .i_src_addr, .o_reg_rdata, .o_reg_ack, .o_event_pending,
        .o_core_reset, .o_chip_reset, .o_jabber, .o_tx_inhibit,
        .o_port_isolated, .o_port_partitioned, .o_rx_repeat_en);
    // ==========================================================
    // Clock and hang guard.
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    // ==========================================================
    // Shared tasks.
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic acc(input logic w, logic [7:0] a, logic [31:0] d);
        @(posedge i_clk);
        i_reg_rd <= !w;
        i_reg_wr <= w;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        i_reg_wr <= 1'b0;
        #1;
        v = o_reg_rdata;
        `CHK(o_reg_ack, 1'b1)
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0000_0000);
        `CHK(v, e)
    endtask
    task automatic pulse(input int k, input int p);
        @(posedge i_clk);
        case (k)
            0: i_frame_start[p] <= 1'b1;
            1: i_col_frame[p] <= 1'b1;
            2: i_clean_frame[p] <= 1'b1;
            3: i_fcc_excess[p] <= 1'b1;
            default: i_sa_valid[p] <= 1'b1;
        endcase
        @(posedge i_clk);
        {i_frame_start, i_col_frame, i_clean_frame} <= '0;
        {i_fcc_excess, i_sa_valid} <= '0;
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_regs();
        rdchk(STATUS_ADDR, 32'h0000_0000);
        rdchk(MASK_ADDR, 32'h0000_0000);
        rdchk(CORE_RST_ADDR, 32'h0000_0000);
        acc(1'b1, MASK_ADDR, 32'hFFFF_FFFF);
        rdchk(MASK_ADDR, 32'h0000_003F);
        acc(1'b1, 8'h55, 32'hFFFF_FFFF);
        rdchk(8'h55, 32'h0000_0000);
        acc(1'b1, MASK_ADDR, 32'h0000_0000);
    endtask
    task automatic t_speed();
        @(posedge i_clk);
        i_reg_clear_mode <= 1'b0;
        i_speed_100[0] <= 1'b0;
        tick(4);
        `CHK(o_event_pending, 1'b1)
        rdchk(STATUS_ADDR, 32'h0000_0001);
        rdchk(STATUS_ADDR, 32'h0000_0000);
        `CHK(o_event_pending, 1'b0)
        @(posedge i_clk) i_reg_clear_mode <= 1'b1;
    endtask
    task automatic t_src_addr();
        pulse(4, 0);
        pulse(4, 0);
        tick(4);
        rdchk(STATUS_ADDR, 32'h0000_0000);
        @(posedge i_clk) i_src_addr[47:0] <= 48'h0000_1111_2223;
        pulse(4, 0);
        tick(4);
        rdchk(STATUS_ADDR, 32'h0000_0002);
        rdchk(STATUS_ADDR, 32'h0000_0002);
        acc(1'b1, STATUS_ADDR, 32'h0000_0002);
        rdchk(STATUS_ADDR, 32'h0000_0000);
    endtask
    task automatic t_fcc_mask();
        acc(1'b1, MASK_ADDR, 32'h0000_0004);
        pulse(3, 2);
        tick(3);
        `CHK(o_event_pending, 1'b0)
        rdchk(STATUS_ADDR, 32'h0000_0004);
        acc(1'b1, MASK_ADDR, 32'h0000_0000);
        tick(2);
        `CHK(o_event_pending, 1'b1)
        acc(1'b1, STATUS_ADDR, 32'h0000_0004);
    endtask
    task automatic t_iso_core();
        repeat (3) pulse(0, 3);
        repeat (2) pulse(0, 1);
        tick(3);
        `CHK(o_port_isolated, 8'h00)
        pulse(0, 1);
        tick(3);
        `CHK(o_port_isolated, 8'h02)
        `CHK(o_rx_repeat_en, 8'hFD)
        rdchk(STATUS_ADDR, 32'h0000_0010);
        acc(1'b1, CORE_RST_ADDR, 32'h0000_0001);
        `CHK(o_core_reset, 1'b1)
        tick(2);
        `CHK(o_port_isolated, 8'h00)
        rdchk(STATUS_ADDR, 32'h0000_0010);
        acc(1'b1, STATUS_ADDR, 32'h0000_0010);
    endtask
    task automatic t_part(input int p, input int n);
        repeat (n) pulse(1, p);
        tick(3);
        `CHK(o_port_partitioned[p], 1'b0)
        pulse(1, p);
        tick(3);
        `CHK(o_port_partitioned[p], 1'b1)
        if (p == 2) rdchk(STATUS_ADDR, 32'h0000_0008);
        acc(1'b1, STATUS_ADDR, 32'h0000_0008);
        pulse(2, p);
        tick(3);
        `CHK(o_port_partitioned[p], 1'b0)
    endtask
    task automatic t_jabber();
        @(posedge i_clk) i_rx_active <= 8'h30;
        tick(J100 + 4);
        `CHK(o_jabber, 1'b1)
        @(posedge i_clk) i_rx_active <= 8'h20;
        tick(4);
        `CHK(o_jabber, 1'b1)
        rdchk(STATUS_ADDR, 32'h0000_0020);
        @(posedge i_clk) i_rx_active <= 8'h00;
        tick(4);
        `CHK(o_jabber, 1'b0)
        @(posedge i_clk) i_tx_active <= 8'h40;
        tick(J10 + 4);
        `CHK(o_tx_inhibit, 8'h40)
        @(posedge i_clk) i_tx_active <= 8'h00;
        tick(int'(IFG_CYC) - 8);
        `CHK(o_tx_inhibit, 8'h40)
        tick(16);
        `CHK(o_tx_inhibit, 8'h00)
    endtask
    task automatic t_chip();
        acc(1'b1, MASK_ADDR, 32'h0000_0001);
        pulse(3, 0);
        tick(3);
        acc(1'b1, CHIP_RST_ADDR, 32'h0000_0001);
        `CHK(o_chip_reset, 1'b1)
        rdchk(STATUS_ADDR, 32'h0000_0000);
        rdchk(MASK_ADDR, 32'h0000_0000);
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence after a 12-cycle reset.
    initial begin
        i_src_addr[47:0] = 48'h0000_1111_2222;
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_regs();
        t_speed();
        t_src_addr();
        t_fcc_mask();
        t_iso_core();
        t_part(2, 60);
        t_part(3, 31);
        t_jabber();
        t_chip();
        summarize();
    end
endmodule
`default_nettype wire
